// ==== common/asr_defs.svh ====
// timing, width and count constants of the static ram access controller
// assumes a single 10 MHz core clock; all times are in ns
`ifndef ASR_DEFS_SVH
`define ASR_DEFS_SVH

`define ASR_CLK_NS 100
`define ASR_ADDR_W 15
`define ASR_DATA_W 8
`define ASR_TMR_W 8

// memory timing in ns
`define ASR_T_AA_NS 20
`define ASR_T_RC_NS 20
`define ASR_T_WP_NS 15
`define ASR_T_WHZ_NS 10
`define ASR_T_DW_NS 11
`define ASR_T_CW_NS 15
`define ASR_T_WR_NS 0

// least time to whole cycles, never below one
`define ASR_CYC_UP(t) ((((t) + `ASR_CLK_NS - 1) / `ASR_CLK_NS) < 1 ? 1 : \
	(((t) + `ASR_CLK_NS - 1) / `ASR_CLK_NS))

`define ASR_ACC_CYC (`ASR_CYC_UP(`ASR_T_AA_NS) > `ASR_CYC_UP(`ASR_T_RC_NS) ? \
	`ASR_CYC_UP(`ASR_T_AA_NS) : `ASR_CYC_UP(`ASR_T_RC_NS))
`define ASR_WP_CYC `ASR_CYC_UP(`ASR_T_WP_NS)
`define ASR_HIZ_CYC `ASR_CYC_UP(`ASR_T_WHZ_NS)
`define ASR_DW_CYC `ASR_CYC_UP(`ASR_T_DW_NS)
`define ASR_CW_CYC `ASR_CYC_UP(`ASR_T_CW_NS)
`define ASR_WR_CYC `ASR_CYC_UP(`ASR_T_WR_NS)

`endif

// ==== common/asr_pkg.sv ====
// types of the static ram access controller
// assumes nothing from asr_defs.svh; the state codes are fixed 3-bit values
package asr_pkg;
	typedef enum logic [2:0]
	{
		ASR_IDLE = 3'h0,
		ASR_RD_ACC = 3'h1,
		ASR_RD_HOLD = 3'h2,
		ASR_W_SETUP = 3'h3,
		ASR_W_HIZ = 3'h4,
		ASR_W_DATA = 3'h5,
		ASR_W_REC = 3'h6
	} asr_state_t;
endpackage

// ==== core/asr_tmr.sv ====
// phase timer: after a load of n, done is high in the n-th cycle
// assumes load is not given while the value is zero
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_tmr #(
	parameter int W = `ASR_TMR_W
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic done
);
	logic [W-1:0] cnt_reg;
	logic run_reg;

	if (W < 2) $error("asr_tmr: width too small");

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cnt_reg <= '0;
			run_reg <= 1'b0;
		end
		else if (load)
		begin
			cnt_reg <= load_val - W'(1);
			run_reg <= 1'b1;
		end
		else if (run_reg)
		begin
			if (cnt_reg == '0)
				run_reg <= 1'b0;
			else
				cnt_reg <= cnt_reg - W'(1);
		end
	end

	assign done = run_reg && (cnt_reg == '0);
endmodule // asr_tmr

// ==== core/asr_ctrl.sv ====
// host side controller for an asynchronous 32k x 8 static ram
// assumes req fields synchronous to core_clk; sram_dq_in already resolved
`timescale 1ns/1ps
`include "asr_defs.svh"

module asr_ctrl
	import asr_pkg::*;
#(
	parameter int ACC_CYC = `ASR_ACC_CYC,
	parameter int WP_CYC = `ASR_WP_CYC,
	parameter int HIZ_CYC = `ASR_HIZ_CYC,
	parameter int DW_CYC = `ASR_DW_CYC,
	parameter int CW_CYC = `ASR_CW_CYC,
	parameter int WR_CYC = `ASR_WR_CYC
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic req,
	input wire logic req_we,
	input wire logic req_cs_ctrl,
	input wire logic req_oe_low,
	input wire logic [`ASR_ADDR_W-1:0] req_addr,
	input wire logic [`ASR_DATA_W-1:0] req_wdata,
	output logic ready,
	output logic rvalid,
	output logic [`ASR_DATA_W-1:0] rdata,
	output logic wdone,
	output logic [`ASR_ADDR_W-1:0] sram_addr,
	output logic sram_cs_n,
	output logic sram_we_n,
	output logic sram_oe_n,
	output logic [`ASR_DATA_W-1:0] sram_dq_out,
	output logic sram_dq_oe_n,
	input wire logic [`ASR_DATA_W-1:0] sram_dq_in
);
	localparam int TW = `ASR_TMR_W;
	localparam int WP_DW = (WP_CYC > DW_CYC) ? WP_CYC : DW_CYC;
	localparam int CW_DW = (CW_CYC > DW_CYC) ? CW_CYC : DW_CYC;
	localparam int WE_LOW_MIN = (WP_CYC > HIZ_CYC + DW_CYC) ? WP_CYC : HIZ_CYC + DW_CYC;
	localparam int DATA_AFTER_HIZ = WE_LOW_MIN - HIZ_CYC;
	localparam int RD_LAT = ACC_CYC + 1;

	if (ACC_CYC < 1 || WP_CYC < 1 || HIZ_CYC < 1 || DW_CYC < 1 || CW_CYC < 1 || WR_CYC < 1)
		$error("asr_ctrl: every count must be at least one");
	if (WE_LOW_MIN >= 2 ** TW || CW_DW >= 2 ** TW || ACC_CYC >= 2 ** TW || WR_CYC >= 2 ** TW)
		$error("asr_ctrl: count too large for the phase timer");

	asr_state_t state_reg;
	logic cs_ctl_reg;
	logic oe_low_reg;
	logic tmr_load;
	logic [TW-1:0] tmr_val;
	logic tmr_done;
	logic take;
	logic ready_q;

	assign ready = ready_q;
	assign take = ready_q && req;

	// ==========================================================
	// phase timer loads
	always_comb
	begin
		tmr_load = 1'b0;
		tmr_val = '0;
		unique case (state_reg)
			ASR_IDLE, ASR_RD_HOLD:
			begin
				if (take)
				begin
					tmr_load = !req_we;
					tmr_val = TW'(ACC_CYC);
				end
			end
			ASR_RD_ACC:
			begin
				tmr_load = 1'b0;
			end
			ASR_W_SETUP:
			begin
				tmr_load = 1'b1;
				if (cs_ctl_reg)
					tmr_val = TW'(CW_DW);
				else if (oe_low_reg)
					tmr_val = TW'(HIZ_CYC);
				else
					tmr_val = TW'(WP_DW);
			end
			ASR_W_HIZ:
			begin
				tmr_load = tmr_done;
				tmr_val = TW'(DATA_AFTER_HIZ);
			end
			ASR_W_DATA:
			begin
				tmr_load = tmr_done;
				tmr_val = TW'(WR_CYC);
			end
			ASR_W_REC:
			begin
				tmr_load = 1'b0;
			end
			default:
			begin
				tmr_load = 1'b0;
			end
		endcase
	end

	asr_tmr #(.W(TW)) u_tmr (
		.core_clk(core_clk),
		.rst(rst),
		.load(tmr_load),
		.load_val(tmr_val),
		.done(tmr_done)
	);

	// ==========================================================
	// access sequencer and pins
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg <= ASR_IDLE;
			ready_q <= 1'b1;
			cs_ctl_reg <= 1'b0;
			oe_low_reg <= 1'b0;
			sram_addr <= '0;
			sram_cs_n <= 1'b1;
			sram_we_n <= 1'b1;
			sram_oe_n <= 1'b1;
			sram_dq_out <= '0;
			sram_dq_oe_n <= 1'b1;
		end
		else
		begin
			unique case (state_reg)
				ASR_IDLE, ASR_RD_HOLD:
				begin
					if (take && !req_we)
					begin
						state_reg <= ASR_RD_ACC;
						ready_q <= 1'b0;
						sram_addr <= req_addr;
						sram_cs_n <= 1'b0;
						sram_oe_n <= 1'b0;
						sram_we_n <= 1'b1;
						sram_dq_oe_n <= 1'b1;
					end
					else if (take)
					begin
						state_reg <= ASR_W_SETUP;
						ready_q <= 1'b0;
						cs_ctl_reg <= req_cs_ctrl;
						oe_low_reg <= req_oe_low;
						sram_addr <= req_addr;
						sram_dq_out <= req_wdata;
						sram_oe_n <= !req_oe_low;
						// select write: strobe first, select later
						sram_we_n <= !req_cs_ctrl;
						sram_cs_n <= req_cs_ctrl;
						sram_dq_oe_n <= 1'b1;
					end
					else if (state_reg == ASR_RD_HOLD)
					begin
						state_reg <= ASR_IDLE;
						sram_cs_n <= 1'b1;
						sram_oe_n <= 1'b1;
					end
				end
				ASR_RD_ACC:
				begin
					if (tmr_done)
					begin
						state_reg <= ASR_RD_HOLD;
						ready_q <= 1'b1;
					end
				end
				ASR_W_SETUP:
				begin
					if (cs_ctl_reg)
					begin
						state_reg <= ASR_W_DATA;
						sram_cs_n <= 1'b0;
						sram_dq_oe_n <= 1'b0;
					end
					else if (oe_low_reg)
					begin
						state_reg <= ASR_W_HIZ;
						sram_we_n <= 1'b0;
					end
					else
					begin
						state_reg <= ASR_W_DATA;
						sram_we_n <= 1'b0;
						sram_dq_oe_n <= 1'b0;
					end
				end
				ASR_W_HIZ:
				begin
					if (tmr_done)
					begin
						state_reg <= ASR_W_DATA;
						sram_dq_oe_n <= 1'b0;
					end
				end
				ASR_W_DATA:
				begin
					if (tmr_done)
					begin
						state_reg <= ASR_W_REC;
						sram_cs_n <= 1'b1;
						sram_we_n <= 1'b1;
						sram_oe_n <= 1'b1;
					end
				end
				ASR_W_REC:
				begin
					if (tmr_done)
					begin
						state_reg <= ASR_IDLE;
						ready_q <= 1'b1;
						sram_dq_oe_n <= 1'b1;
					end
				end
				default:
				begin
					state_reg <= ASR_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// answers to the user side
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			rvalid <= 1'b0;
			rdata <= '0;
			wdone <= 1'b0;
		end
		else
		begin
			rvalid <= (state_reg == ASR_RD_ACC) && tmr_done;
			wdone <= (state_reg == ASR_W_REC) && tmr_done;
			if ((state_reg == ASR_RD_ACC) && tmr_done)
				rdata <= sram_dq_in;
		end
	end

	// ==========================================================
	// checks
	logic [TW-1:0] we_low_cnt;
	logic [TW-1:0] cs_low_cnt;

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			we_low_cnt <= '0;
			cs_low_cnt <= '0;
		end
		else
		begin
			we_low_cnt <= sram_we_n ? '0 : we_low_cnt + TW'(1);
			if (sram_cs_n)
				cs_low_cnt <= '0;
			else if (!sram_we_n)
				cs_low_cnt <= cs_low_cnt + TW'(1);
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_read_we_high: assert property (((state_reg == ASR_RD_ACC) || (state_reg == ASR_RD_HOLD))
		&& !sram_cs_n |-> sram_we_n)
		else $error("write strobe low during a read");
	a_no_contention: assert property (!sram_oe_n && sram_we_n |-> sram_dq_oe_n)
		else $error("data driven while memory outputs on");
	a_hiz_first: assert property ($fell(sram_dq_oe_n) && !sram_oe_n |-> !$past(sram_we_n))
		else $error("data driven before strobe turned outputs off");
	a_pulse_oe_low: assert property ($rose(sram_we_n) && !$past(sram_oe_n)
		&& !$past(sram_cs_n) && !cs_ctl_reg |-> we_low_cnt >= TW'(WE_LOW_MIN))
		else $error("strobe pulse too short with drive low");
	a_pulse_oe_high: assert property ($rose(sram_we_n) && $past(sram_oe_n) && !cs_ctl_reg
		|-> we_low_cnt >= TW'(WP_DW))
		else $error("strobe pulse too short");
	a_cs_write_len: assert property ($rose(sram_cs_n) && cs_ctl_reg && !$past(sram_we_n)
		|-> cs_low_cnt >= TW'(CW_DW))
		else $error("select write too short");
	a_cs_after_we: assert property ($fell(sram_cs_n) && !sram_we_n |-> !$past(sram_we_n))
		else $error("select fell before strobe in select write");
	a_addr_in_write: assert property (!sram_we_n && !$past(sram_we_n) |-> $stable(sram_addr))
		else $error("address moved during write");
	a_recovery_hold: assert property ($rose(sram_we_n) |-> !sram_dq_oe_n && sram_cs_n)
		else $error("data released at end of write");
	a_read_latency: assert property (take && !req_we |-> ##[RD_LAT:RD_LAT] rvalid)
		else $error("read answer not on time");
	a_standby: assert property (ready_q && !req |=> sram_cs_n)
		else $error("select left low while idle");
	a_addr_at_cs: assert property ($fell(sram_cs_n) && sram_we_n |-> sram_addr == $past(req_addr))
		else $error("address not set with select");

	c_read: cover property (take && !req_we ##[RD_LAT:RD_LAT] rvalid);
	c_back_to_back: cover property (rvalid && take && !req_we && !sram_cs_n);
	c_we_write_oe_low: cover property (take && req_we && !req_cs_ctrl && req_oe_low);
	c_cs_write: cover property (take && req_we && req_cs_ctrl ##[1:20] wdone);
endmodule // asr_ctrl

// ==== test/asr_sram_model.sv ====
// behavioural 32k x 8 static ram on the controller pins, resolves the data bus
// assumes pins change just after core_clk edges; no pull on the data bus
`timescale 1ns/1ps
`include "asr_defs.svh"
module asr_sram_model (
	input wire logic core_clk,
	input wire logic [`ASR_ADDR_W-1:0] addr,
	input wire logic cs_n,
	input wire logic we_n,
	input wire logic oe_n,
	input wire logic [`ASR_DATA_W-1:0] host_dq,
	input wire logic host_dq_oe_n,
	output logic [`ASR_DATA_W-1:0] dq,
	output logic clash
);
	// ==========
	// storage and drive
	logic [`ASR_DATA_W-1:0] mem [0:32767];
	logic [`ASR_DATA_W-1:0] last_reg = 8'h00;
	logic mem_drv;
	assign mem_drv = !cs_n && !oe_n && we_n;
	assign clash = mem_drv && !host_dq_oe_n;
	always_comb
	begin
		if (!host_dq_oe_n)
			dq = host_dq;
		else if (mem_drv)
			dq = mem[addr];
		else
			dq = ~last_reg;
	end
	always @(posedge core_clk)
	begin
		last_reg <= dq;
		if (!cs_n && !we_n)
			mem[addr] <= dq;
	end
endmodule // asr_sram_model

// ==== test/async_sram_32kx8_access_test.sv ====
// self-checking bench of asr_ctrl against a ram model and a reference memory
// assumes asr_sram_model.sv and the design files are compiled first
`timescale 1ns/1ps
`include "asr_defs.svh"
module async_sram_32kx8_access_test;
	import asr_pkg::*;
	localparam int ACC = 1, WP = 1, HIZ = 1, DW = 1, CW = 1, WR = 1;
	logic core_clk = 1'b0, rst = 1'b1, req = 1'b0, req_we = 1'b0;
	logic req_cs_ctrl = 1'b0, req_oe_low = 1'b0;
	logic [14:0] req_addr = 15'h0000;
	logic [7:0] req_wdata = 8'h00;
	logic ready, rvalid, wdone, sram_cs_n, sram_we_n, sram_oe_n, sram_dq_oe_n, clash;
	logic [7:0] rdata, sram_dq_out, sram_dq_in;
	logic [14:0] sram_addr;
	logic [7:0] ref_mem [int];
	int err_count = 0;
	int comparisons = 0;
	always #50 core_clk = ~core_clk;
	asr_ctrl #(.ACC_CYC(ACC), .WP_CYC(WP), .HIZ_CYC(HIZ), .DW_CYC(DW), .CW_CYC(CW),
		.WR_CYC(WR)) u_dut (.core_clk(core_clk), .rst(rst), .req(req), .req_we(req_we),
		.req_cs_ctrl(req_cs_ctrl), .req_oe_low(req_oe_low), .req_addr(req_addr),
		.req_wdata(req_wdata), .ready(ready), .rvalid(rvalid), .rdata(rdata), .wdone(wdone),
		.sram_addr(sram_addr), .sram_cs_n(sram_cs_n), .sram_we_n(sram_we_n),
		.sram_oe_n(sram_oe_n), .sram_dq_out(sram_dq_out), .sram_dq_oe_n(sram_dq_oe_n),
		.sram_dq_in(sram_dq_in));
	asr_sram_model u_mem (.core_clk(core_clk), .addr(sram_addr), .cs_n(sram_cs_n),
		.we_n(sram_we_n), .oe_n(sram_oe_n), .host_dq(sram_dq_out),
		.host_dq_oe_n(sram_dq_oe_n), .dq(sram_dq_in), .clash(clash));
	// ==========
	// compare and closing
	task automatic chk_val(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_cyc(input string what, input int exp, input int got);
		comparisons++;
		if (got != exp)
		begin
			err_count++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	task automatic close_out;
		if (err_count == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(negedge core_clk)
	begin
		if (rst === 1'b0)
			chk_val("bus clash", 16'h0, 16'(clash));
	end
	// ==========
	// request driver
	function automatic int pulse(input logic cs_c, input logic oe_l);
		if (cs_c)
			return (CW > DW) ? CW : DW;
		if (oe_l)
			return (WP > HIZ + DW) ? WP : HIZ + DW;
		return (WP > DW) ? WP : DW;
	endfunction
	task automatic issue(input logic we, input logic cs_c, input logic oe_l,
		input logic [14:0] a, input logic [7:0] d, output int lat, output int low);
		int n;
		n = 0;
		req = 1'b1;
		req_we = we;
		req_cs_ctrl = cs_c;
		req_oe_low = oe_l;
		req_addr = a;
		req_wdata = d;
		while (ready !== 1'b1 && n < 40)
		begin
			@(posedge core_clk);
			#1;
			n++;
		end
		chk_val("ready", 16'h1, 16'(ready));
		@(posedge core_clk);
		#1;
		req = 1'b0;
		lat = 1;
		low = 0;
		while ((we ? wdone : rvalid) !== 1'b1 && lat < 40)
		begin
			if ((cs_c ? sram_cs_n : sram_we_n) === 1'b0)
				low++;
			if (!we)
				chk_val("read strobe", 16'h1, 16'(sram_we_n));
			if (sram_cs_n === 1'b0)
				chk_val("address pin", 16'(a), 16'(sram_addr));
			if (we && sram_we_n === 1'b0)
				chk_val("write drive pin", 16'(!oe_l), 16'(sram_oe_n));
			@(posedge core_clk);
			#1;
			lat++;
		end
	endtask
	task automatic wr(input logic [14:0] a, input logic [7:0] d, input logic cs_c,
		input logic oe_l);
		int lat, low;
		issue(1'b1, cs_c, oe_l, a, d, lat, low);
		ref_mem[a] = d;
		chk_cyc("write latency", 2 + pulse(cs_c, oe_l) + WR, lat);
		chk_cyc("write pulse", pulse(cs_c, oe_l), low);
	endtask
	task automatic rd(input logic [14:0] a);
		int lat, low;
		issue(1'b0, 1'($urandom_range(1)), 1'($urandom_range(1)), a, 8'($urandom), lat, low);
		chk_val("read data", 16'(ref_mem[a]), 16'(rdata));
		chk_cyc("read latency", ACC + 1, lat);
	endtask
	// ==========
	// main sequence
	initial
	begin
		logic [14:0] a;
		void'($urandom(32'h7F8A));
		repeat (3) @(posedge core_clk);
		#1;
		rst = 1'b0;
		for (int m = 0; m < 4; m++)
		begin
			for (int k = 0; k < 4; k++)
			begin
				a = 15'($urandom);
				wr(a, 8'($urandom), m[1], m[0]);
				rd(a);
			end
		end
		wr(15'h0000, 8'hA5, 1'b0, 1'b1);
		wr(15'h7FFF, 8'h5A, 1'b1, 1'b1);
		rd(15'h0000);
		rd(15'h7FFF);
		rd(a);
		rst = 1'b1;
		#1;
		chk_val("reset select", 16'h1, 16'(sram_cs_n));
		chk_val("reset drive", 16'h1, 16'(sram_dq_oe_n));
		chk_val("reset strobe", 16'h1, 16'(sram_we_n));
		chk_val("reset output drive", 16'h1, 16'(sram_oe_n));
		chk_val("reset ready", 16'h1, 16'(ready));
		chk_val("reset read data", 16'h0, 16'(rdata));
		chk_val("reset answers", 16'h0, 16'({rvalid, wdone}));
		@(posedge core_clk);
		#1;
		rst = 1'b0;
		rd(15'h7FFF);
		close_out;
	end
	initial
	begin
		#(100 * 4000);
		err_count++;
		close_out;
	end
endmodule // async_sram_32kx8_access_test
